//--- rtl/smart_cmd_defs.svh
// Register offsets, field positions, codes and timing for the monitoring command block
`ifndef SMART_CMD_DEFS_SVH
`define SMART_CMD_DEFS_SVH

// ********************
// Register offsets
// ********************
`define OFF_SUBCMD 8'h00
`define OFF_TALLY 8'h04
`define OFF_INDEX 8'h08
`define OFF_SIG_LO 8'h0C
`define OFF_SIG_HI 8'h10
`define OFF_DRVHEAD 8'h14
`define OFF_COMMAND 8'h18
`define OFF_STATUS 8'h1C
`define OFF_CONFIG 8'h20
`define OFF_LOG_SEL 8'h24
`define OFF_LOG_DATA 8'h28
`define OFF_ERR_TOTAL 8'h2C

// ********************
// Field positions and reset values
// ********************
`define DRV_SEL_BIT 4
`define ST_BSY 0
`define ST_INTRQ 1
`define ST_ERR 2
`define ST_ABORT 3
`define ST_ENABLED 4
`define ST_DEGRADED 5
`define ST_NV_LOADED 6
`define ST_PM_LSB 8
`define ST_LOGCNT_LSB 12
`define TF_RESET 8'h00
`define IDENT_W82_SUPPORT_BIT 0

// ********************
// Command and subcommand codes
// ********************
`define CMD_MONITOR 8'hB0
`define SIG_LOW_VAL 8'h4F
`define SIG_HIGH_VAL 8'hC2
`define SUB_ENABLE 8'hD8
`define SUB_DISABLE 8'hD9
`define SUB_RET_STATUS 8'hDA
`define SUB_AUTOSAVE 8'hD2
`define SUB_SAVE 8'hD3
`define SUB_AUTO_OFFLINE 8'hDB
`define SUB_OFFLINE_NOW 8'hD4
`define SUB_LOG_READ 8'hD5
`define SUB_LOG_WRITE 8'hD6
`define CMD_IDLE_IMM_A 8'hE1
`define CMD_IDLE_IMM_B 8'h95
`define CMD_STBY_IMM_A 8'hE0
`define CMD_STBY_IMM_B 8'h94
`define CMD_SLEEP_A 8'hE6
`define CMD_SLEEP_B 8'h99
`define CMD_IDLE_A 8'hE3
`define CMD_IDLE_B 8'h97
`define CMD_STBY_A 8'hE2
`define CMD_STBY_B 8'h96

// ********************
// Timing
// ********************
`define CLK_PERIOD_NS 10
`define STAMP_TICK_NS 1000000
`define LOG_DEPTH 5

`endif

//--- rtl/smart_cmd_pkg.sv
// Types shared by the monitoring command block
package smart_cmd_pkg;

	typedef enum logic [2:0] {st_load, st_idle, st_exec, st_nvwr, st_done} cmd_state_t;

	typedef enum logic [1:0] {pm_active, pm_idle, pm_standby, pm_sleep} pm_state_t;

endpackage

//--- rtl/smart_cmd.sv
// Monitoring feature command interpreter with AXI4-Lite task-file access
// Overview of operation
// - Every monitoring operation uses command code B0h, split apart by the feature byte.
// - Signature low must be 4Fh, high C2h; bad feature or signature aborts.
// - Enable operation D8h: busy, switch monitoring on, drop busy, raise interrupt.
// - Disable operation D9h: busy, switch monitoring and its timers off, interrupt.
// - Disable while monitoring is off is aborted.
// - While off, every monitoring operation except enable is aborted.
// - Enabled state lives in non-volatile storage across power cycles.
// - Attributes are neither monitored nor saved unless monitoring is enabled.
// - Repeated enable leaves stored attribute values untouched.
// - Factory state of monitoring is disabled; system software enables it.
// - Identify data word 82 bit 0 advertises the monitoring feature.
// - Any attribute at or below its threshold reports impending fault.
// - Thresholds are fixed constants with no host write path.
// - Keep the last five errors, except while in standby or sleep.
// - Each log entry holds recent commands and the error's time stamp.
// - Disabling does not stop logging; it only hides the log from reads.
// - Firmware update wipes the log; update software zeroes the lifetime count.
// - When enabled, idle-immediate, standby-immediate and sleep save attributes.
// - With the standby timer running, save attributes before idle-to-standby.
// - Drive-select bit 4 picks the device; only matching commands are acted on.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "smart_cmd_defs.svh"

module smart_cmd
	import smart_cmd_pkg::*;
#(
	parameter int N_ATTR = 4,
	parameter logic [N_ATTR*8-1:0] ATTR_THRESH = {N_ATTR{8'h10}},
	parameter int TICK_CYCLES = `STAMP_TICK_NS / `CLK_PERIOD_NS
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic nv_ready,
	input wire logic nv_enabled,
	output logic nv_wr,
	output logic nv_wr_data,
	input wire logic nv_wr_ack,
	input wire logic [N_ATTR*8-1:0] attr_values,
	output logic monitor_en,
	output logic attr_save,
	output logic degraded,
	output logic ext_sub_req,
	output logic [7:0] ext_sub_code,
	input wire logic standby_due,
	input wire logic err_event,
	input wire logic fw_update,
	output logic [15:0] ident_word82,
	output logic intrq
);

	// ********************
	// Helpers
	// ********************
	function automatic logic any_at_or_below(input logic [N_ATTR*8-1:0] vals);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N_ATTR; i++)
			if (vals[i*8 +: 8] <= ATTR_THRESH[i*8 +: 8])
				hit = 1'b1;
		return hit;
	endfunction

	function automatic logic is_code(input logic [7:0] c, input logic [7:0] a,
		input logic [7:0] b);
		return (c == a) || (c == b);
	endfunction

	// ********************
	// State
	// ********************
	cmd_state_t state_r;
	pm_state_t pm_r;
	logic [7:0] subcmd_r, tally_r, index_r, sig_lo_r, sig_hi_r, drvhead_r, cmd_r;
	logic dev_id_r;
	logic bsy_r, err_r, abort_r, enabled_r, nv_loaded_r;
	logic [2:0] log_sel_r, log_wp_r, log_cnt_r;
	logic [31:0] log_mem [0:`LOG_DEPTH-1];
	logic [7:0] hist0_r, hist1_r;
	logic [15:0] err_total_r, stamp_r;
	logic [31:0] tick_cnt_r;
	logic aw_held_r, w_held_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;

	// ********************
	// Bus decode
	// ********************
	wire logic aw_take = s_axi_awvalid && s_axi_awready;
	wire logic w_take = s_axi_wvalid && s_axi_wready;
	wire logic ar_take = s_axi_arvalid && s_axi_arready;
	wire logic do_wr = aw_held_r && w_held_r && !s_axi_bvalid;
	wire logic wr_lane0 = do_wr && wstrb_r[0];
	wire logic [7:0] wbyte = wdata_r[7:0];
	wire logic wr_map_ok = (awaddr_r[1:0] == 2'b00) && (awaddr_r <= `OFF_ERR_TOTAL);
	wire logic rd_map_ok = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= `OFF_ERR_TOTAL);
	// Task file is frozen while busy, as a host may not load it mid-command
	wire logic tf_wr = wr_lane0 && !bsy_r;
	wire logic wr_subcmd = tf_wr && (awaddr_r == `OFF_SUBCMD);
	wire logic wr_tally = tf_wr && (awaddr_r == `OFF_TALLY);
	wire logic wr_index = tf_wr && (awaddr_r == `OFF_INDEX);
	wire logic wr_sig_lo = tf_wr && (awaddr_r == `OFF_SIG_LO);
	wire logic wr_sig_hi = tf_wr && (awaddr_r == `OFF_SIG_HI);
	wire logic wr_drvhead = tf_wr && (awaddr_r == `OFF_DRVHEAD);
	wire logic wr_cmd = tf_wr && (awaddr_r == `OFF_COMMAND);
	wire logic wr_config = wr_lane0 && (awaddr_r == `OFF_CONFIG);
	wire logic wr_log_sel = wr_lane0 && (awaddr_r == `OFF_LOG_SEL);
	wire logic wr_err_total = wr_lane0 && (awaddr_r == `OFF_ERR_TOTAL);
	wire logic rd_status = ar_take && (s_axi_araddr == `OFF_STATUS);
	wire logic dev_match = (drvhead_r[`DRV_SEL_BIT] == dev_id_r);
	wire logic cmd_start = wr_cmd && (state_r == st_idle) && dev_match;

	// ********************
	// Command decode
	// ********************
	wire logic is_monitor = (cmd_r == `CMD_MONITOR);
	wire logic sig_ok = (sig_lo_r == `SIG_LOW_VAL) && (sig_hi_r == `SIG_HIGH_VAL);
	wire logic sub_enable = (subcmd_r == `SUB_ENABLE);
	wire logic sub_disable = (subcmd_r == `SUB_DISABLE);
	wire logic sub_other = (subcmd_r == `SUB_RET_STATUS) || (subcmd_r == `SUB_AUTOSAVE)
		|| (subcmd_r == `SUB_SAVE) || (subcmd_r == `SUB_AUTO_OFFLINE)
		|| (subcmd_r == `SUB_OFFLINE_NOW) || (subcmd_r == `SUB_LOG_READ)
		|| (subcmd_r == `SUB_LOG_WRITE);
	wire logic cmd_idle_imm = is_code(cmd_r, `CMD_IDLE_IMM_A, `CMD_IDLE_IMM_B);
	wire logic cmd_stby_imm = is_code(cmd_r, `CMD_STBY_IMM_A, `CMD_STBY_IMM_B);
	wire logic cmd_sleep = is_code(cmd_r, `CMD_SLEEP_A, `CMD_SLEEP_B);
	wire logic cmd_idle = is_code(cmd_r, `CMD_IDLE_A, `CMD_IDLE_B);
	wire logic cmd_stby = is_code(cmd_r, `CMD_STBY_A, `CMD_STBY_B);
	wire logic cmd_power = cmd_idle_imm || cmd_stby_imm || cmd_sleep || cmd_idle || cmd_stby;
	// Feature or signature faults abort before the enabled state is even looked at
	wire logic mon_abort = is_monitor && (!sig_ok
		|| (!enabled_r && !sub_enable)
		|| (enabled_r && !sub_enable && !sub_disable && !sub_other));
	wire logic exec_abort = mon_abort || (!is_monitor && !cmd_power);
	wire logic want_on = is_monitor && !mon_abort && sub_enable && !enabled_r;
	wire logic want_off = is_monitor && !mon_abort && sub_disable;
	wire logic exec_ext = is_monitor && !mon_abort && sub_other;
	wire logic exec_save = !exec_abort && enabled_r && (cmd_idle_imm || cmd_stby_imm
		|| cmd_sleep);
	wire logic timer_save = standby_due && (pm_r == pm_idle) && enabled_r;
	wire logic log_ok = err_event && (pm_r != pm_standby) && (pm_r != pm_sleep);
	wire logic intrq_set = (state_r == st_done);
	wire logic [2:0] wp_next = (log_wp_r == 3'(`LOG_DEPTH - 1)) ? 3'h0 : log_wp_r + 3'h1;
	wire logic [31:0] log_word = (enabled_r && log_sel_r < 3'(`LOG_DEPTH))
		? log_mem[log_sel_r] : 32'h0000_0000;

	// ********************
	// Read mux
	// ********************
	logic [31:0] rd_word;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`OFF_TALLY: rd_word = {24'h00_0000, tally_r};
			`OFF_INDEX: rd_word = {24'h00_0000, index_r};
			`OFF_SIG_LO: rd_word = {24'h00_0000, sig_lo_r};
			`OFF_SIG_HI: rd_word = {24'h00_0000, sig_hi_r};
			`OFF_DRVHEAD: rd_word = {24'h00_0000, drvhead_r};
			`OFF_STATUS:
			begin
				rd_word[`ST_BSY] = bsy_r;
				rd_word[`ST_INTRQ] = intrq;
				rd_word[`ST_ERR] = err_r;
				rd_word[`ST_ABORT] = abort_r;
				rd_word[`ST_ENABLED] = enabled_r;
				rd_word[`ST_DEGRADED] = degraded;
				rd_word[`ST_NV_LOADED] = nv_loaded_r;
				rd_word[`ST_PM_LSB +: 2] = pm_r;
				rd_word[`ST_LOGCNT_LSB +: 3] = log_cnt_r;
			end
			`OFF_CONFIG: rd_word = {31'h0000_0000, dev_id_r};
			`OFF_LOG_SEL: rd_word = {29'h0000_0000, log_sel_r};
			`OFF_LOG_DATA: rd_word = log_word;
			`OFF_ERR_TOTAL: rd_word = {16'h0000, err_total_r};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ********************
	// AXI4-Lite slave
	// ********************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map_ok ? 2'h0 : 2'h2;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end
		else if (ar_take)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_map_ok ? rd_word : 32'h0000_0000;
			s_axi_rresp <= rd_map_ok ? 2'h0 : 2'h2;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ********************
	// Task file
	// ********************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			subcmd_r <= `TF_RESET;
			tally_r <= `TF_RESET;
			index_r <= `TF_RESET;
			sig_lo_r <= `TF_RESET;
			sig_hi_r <= `TF_RESET;
			drvhead_r <= `TF_RESET;
			cmd_r <= `TF_RESET;
			dev_id_r <= 1'b0;
			log_sel_r <= 3'h0;
		end
		else
		begin
			if (wr_subcmd) subcmd_r <= wbyte;
			if (wr_tally) tally_r <= wbyte;
			if (wr_index) index_r <= wbyte;
			if (wr_sig_lo) sig_lo_r <= wbyte;
			if (wr_sig_hi) sig_hi_r <= wbyte;
			if (wr_drvhead) drvhead_r <= wbyte;
			if (cmd_start) cmd_r <= wbyte;
			if (wr_config) dev_id_r <= wbyte[0];
			if (wr_log_sel) log_sel_r <= wbyte[2:0];
		end
	end

	// ********************
	// Command sequencer
	// ********************
	// Busy covers the persisted-state load, so no command lands before it
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= st_load;
			bsy_r <= 1'b1;
			enabled_r <= 1'b0;
			nv_loaded_r <= 1'b0;
			err_r <= 1'b0;
			abort_r <= 1'b0;
			nv_wr <= 1'b0;
			nv_wr_data <= 1'b0;
			ext_sub_req <= 1'b0;
			ext_sub_code <= 8'h00;
			hist0_r <= 8'h00;
			hist1_r <= 8'h00;
		end
		else
		begin
			ext_sub_req <= 1'b0;
			case (state_r)
				st_load:
					if (nv_ready)
					begin
						enabled_r <= nv_enabled;
						nv_loaded_r <= 1'b1;
						bsy_r <= 1'b0;
						state_r <= st_idle;
					end
				st_idle:
					if (cmd_start)
					begin
						bsy_r <= 1'b1;
						err_r <= 1'b0;
						abort_r <= 1'b0;
						hist1_r <= hist0_r;
						hist0_r <= wbyte;
						state_r <= st_exec;
					end
				st_exec:
				begin
					err_r <= exec_abort;
					abort_r <= exec_abort;
					if (exec_ext)
					begin
						ext_sub_req <= 1'b1;
						ext_sub_code <= subcmd_r;
					end
					if (want_on || want_off)
					begin
						nv_wr <= 1'b1;
						nv_wr_data <= want_on;
						state_r <= st_nvwr;
					end
					else
						state_r <= st_done;
				end
				st_nvwr:
					if (nv_wr_ack)
					begin
						nv_wr <= 1'b0;
						enabled_r <= nv_wr_data;
						state_r <= st_done;
					end
				st_done:
				begin
					bsy_r <= 1'b0;
					state_r <= st_idle;
				end
				default: state_r <= st_load;
			endcase
		end
	end

	// Interrupt pending is cleared by a status read; a new completion wins
	always_ff @(posedge clk)
	begin
		if (rst)
			intrq <= 1'b0;
		else if (intrq_set)
			intrq <= 1'b1;
		else if (rd_status)
			intrq <= 1'b0;
	end

	// ********************
	// Power mode and attribute saving
	// ********************
	// Sleep is left by reset or by any idle or standby power command that completes without abort
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pm_r <= pm_active;
			attr_save <= 1'b0;
		end
		else
		begin
			attr_save <= (state_r == st_exec && exec_save) || timer_save;
			if (state_r == st_exec && !exec_abort)
			begin
				if (cmd_idle_imm || cmd_idle) pm_r <= pm_idle;
				if (cmd_stby_imm || cmd_stby) pm_r <= pm_standby;
				if (cmd_sleep) pm_r <= pm_sleep;
			end
			else if (standby_due && pm_r == pm_idle)
				pm_r <= pm_standby;
		end
	end

	// Thresholds are parameters only; no register can reach them
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			monitor_en <= 1'b0;
			degraded <= 1'b0;
			ident_word82 <= 16'h0000;
		end
		else
		begin
			monitor_en <= enabled_r;
			degraded <= enabled_r && any_at_or_below(attr_values);
			ident_word82 <= 16'h0001 << `IDENT_W82_SUPPORT_BIT;
		end
	end

	// ********************
	// Error log
	// ********************
	// Time stamp counts coarse ticks so 16 bits span about a minute per wrap
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tick_cnt_r <= 32'h0000_0000;
			stamp_r <= 16'h0000;
		end
		else if (tick_cnt_r == 32'(TICK_CYCLES - 1))
		begin
			tick_cnt_r <= 32'h0000_0000;
			stamp_r <= stamp_r + 16'h0001;
		end
		else
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
	end

	// Logging runs regardless of the enabled state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			log_wp_r <= 3'h0;
			log_cnt_r <= 3'h0;
			err_total_r <= 16'h0000;
		end
		else
		begin
			if (fw_update)
			begin
				log_wp_r <= 3'h0;
				log_cnt_r <= 3'h0;
			end
			else if (log_ok)
			begin
				log_mem[log_wp_r] <= {hist1_r, hist0_r, stamp_r};
				log_wp_r <= wp_next;
				if (log_cnt_r != 3'(`LOG_DEPTH))
					log_cnt_r <= log_cnt_r + 3'h1;
			end
			if (log_ok)
				err_total_r <= err_total_r + 16'h0001;
			else if (wr_err_total)
				err_total_r <= 16'h0000;
		end
	end

endmodule

//--- test/nv_store_model.sv
// Behavioural non-volatile store holding the persisted monitoring state
`timescale 1ns/1ps

module nv_store_model
#(
	parameter int DLY = 5
)
(
	input wire logic clk,
	input wire logic rst,
	output logic nv_ready,
	output logic nv_enabled,
	input wire logic nv_wr,
	input wire logic nv_wr_data,
	output logic nv_wr_ack,
	output logic stored
);
	logic [3:0] cnt_r = 4'h0;
	// Survives every design reset; the factory value is off
	logic kept_r = 1'b0;

	// Inverted until loaded, so an early look by the design reads wrong
	assign nv_enabled = nv_ready ? kept_r : ~kept_r;
	assign stored = kept_r;

	always @(posedge clk)
	begin
		nv_wr_ack <= 1'b0;
		cnt_r <= cnt_r + 4'h1;
		if (rst)
		begin
			nv_ready <= 1'b0;
			cnt_r <= 4'h0;
		end
		else if (nv_ready && !nv_wr)
			cnt_r <= 4'h0;
		else if (cnt_r == 4'(DLY))
		begin
			cnt_r <= 4'h0;
			nv_ready <= 1'b1;
			nv_wr_ack <= nv_ready;
			if (nv_ready)
				kept_r <= nv_wr_data;
		end
	end
endmodule

//--- test/smart_cmd_asserts.sv
// Concurrent checks on the monitoring command block's ports
`timescale 1ns/1ps

module smart_cmd_chk
#(
	parameter int N_ATTR = 4,
	parameter logic [N_ATTR*8-1:0] ATTR_THRESH = {N_ATTR{8'h10}}
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic nv_wr,
	input wire logic nv_wr_data,
	input wire logic nv_wr_ack,
	input wire logic [N_ATTR*8-1:0] attr_values,
	input wire logic monitor_en,
	input wire logic attr_save,
	input wire logic degraded,
	input wire logic ext_sub_req,
	input wire logic [7:0] ext_sub_code,
	input wire logic [15:0] ident_word82
);
	logic any_low;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	always_comb
	begin
		any_low = 1'b0;
		for (int i = 0; i < N_ATTR; i++)
			if (attr_values[i*8 +: 8] <= ATTR_THRESH[i*8 +: 8])
				any_low = 1'b1;
	end

	word82_set_a: assert property ($past(!rst) |-> ident_word82 == 16'h0001)
		else $error("identify word 82 wrong");
	save_gated_a: assert property (attr_save |-> monitor_en)
		else $error("attribute save while monitoring off");
	fault_track_a: assert property (monitor_en |-> degraded == $past(any_low))
		else $error("degraded flag disagrees with attributes");
	sub_forward_a: assert property (ext_sub_req |-> monitor_en && ext_sub_code != 8'hD8
		&& ext_sub_code != 8'hD9) else $error("subcommand forwarded wrongly");
	nv_hold_a: assert property (nv_wr && !nv_wr_ack |=> nv_wr && $stable(nv_wr_data))
		else $error("store write dropped before ack");
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted with response pending");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted with data pending");

	cover property (nv_wr_ack);
	cover property (attr_save);
	cover property (ext_sub_req);
endmodule

bind smart_cmd smart_cmd_chk #(.N_ATTR(N_ATTR), .ATTR_THRESH(ATTR_THRESH)) smart_cmd_chk_i (
	.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .nv_wr, .nv_wr_data,
	.nv_wr_ack, .attr_values, .monitor_en, .attr_save, .degraded, .ext_sub_req,
	.ext_sub_code, .ident_word82
);

//--- test/testbench.sv
// Self-checking bench for the monitoring command block
`timescale 1ns/1ps
`include "smart_cmd_defs.svh"

module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	logic [31:0] s_axi_rdata, st;
	logic nv_ready, nv_enabled, nv_wr, nv_wr_data, nv_wr_ack, stored;
	logic [31:0] attr_values = 32'h80808080;
	logic standby_due = 1'b0;
	logic err_event = 1'b0;
	logic fw_update = 1'b0;
	logic monitor_en, attr_save, degraded, ext_sub_req, intrq;
	logic [7:0] ext_sub_code;
	logic [7:0] ext_seen = 8'h00;
	logic [15:0] ident_word82;
	logic [7:0] pwr [3] = '{`CMD_IDLE_IMM_A, `CMD_STBY_IMM_B, `CMD_SLEEP_A};
	int mismatches = 0;
	int n_tests = 0;
	int saves = 0;
	int nvw = 0;
	int cnt;

	smart_cmd #(.TICK_CYCLES(4)) smart_cmd_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_ready, .nv_enabled,
		.nv_wr, .nv_wr_data, .nv_wr_ack, .attr_values, .monitor_en, .attr_save, .degraded,
		.ext_sub_req, .ext_sub_code, .standby_due, .err_event, .fw_update, .ident_word82,
		.intrq);
	nv_store_model nv_store_model_i (.clk, .rst, .nv_ready, .nv_enabled, .nv_wr,
		.nv_wr_data, .nv_wr_ack, .stored);

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		if (attr_save)
			saves <= saves + 1;
		if (nv_wr_ack)
			nvw <= nvw + 1;
		if (ext_sub_req)
			ext_seen <= ext_sub_code;
	end

	// ********************
	// Bus and check tasks
	// ********************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		st = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Busy must drop before the persisted state may be trusted
	task automatic do_reset;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		do
			rd(`OFF_STATUS);
		while (st[6] !== 1'b1 || st[0] !== 1'b0);
	endtask

	task automatic cmd(input logic [7:0] c);
		wr(`OFF_COMMAND, 32'(c));
		do
			rd(`OFF_STATUS);
		while (st[0] === 1'b1);
		chk("intrq", 32'(st[1]), 32'h1);
		chk("intrq pin", 32'(intrq), 32'h0);
	endtask

	task automatic run(input logic [7:0] f, input logic [7:0] lo, input logic ab);
		wr(`OFF_SUBCMD, 32'(f));
		wr(`OFF_SIG_LO, 32'(lo));
		wr(`OFF_SIG_HI, 32'(`SIG_HIGH_VAL));
		cmd(`CMD_MONITOR);
		chk("abort", 32'(st[3]), 32'(ab));
	endtask

	task automatic pulse(input int k);
		@(posedge clk);
		{fw_update, err_event, standby_due} <= 3'(1 << k);
		@(posedge clk);
		{fw_update, err_event, standby_due} <= 3'h0;
		repeat (4) @(posedge clk);
	endtask

	task automatic logchk(input int d);
		rd(`OFF_STATUS);
		chk("log count", 32'(st[14:12]), 32'(cnt + d));
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ********************
	// Test sequence
	// ********************
	initial
	begin
		do_reset();
		chk("ident", 32'(ident_word82), 32'h1);
		chk("enabled", 32'(st[4]), 32'h0);
		run(`SUB_DISABLE, `SIG_LOW_VAL, 1'b1);
		run(`SUB_RET_STATUS, `SIG_LOW_VAL, 1'b1);
		run(`SUB_ENABLE, 8'h4E, 1'b1);
		chk("monitor", 32'(monitor_en), 32'h0);
		run(`SUB_ENABLE, `SIG_LOW_VAL, 1'b0);
		chk("stored", 32'(stored), 32'h1);
		cnt = nvw;
		run(`SUB_ENABLE, `SIG_LOW_VAL, 1'b0);
		chk("store writes", 32'(nvw), 32'(cnt));
		run(8'h00, `SIG_LOW_VAL, 1'b1);
		run(`SUB_SAVE, `SIG_LOW_VAL, 1'b0);
		chk("forwarded", 32'(ext_seen), 32'(`SUB_SAVE));
		attr_values <= 32'h80801080;
		rd(`OFF_STATUS);
		chk("degraded", 32'(st[5]), 32'h1);
		attr_values <= 32'h80801180;
		rd(`OFF_STATUS);
		chk("degraded", 32'(st[5]), 32'h0);
		cnt = int'(st[14:12]);
		pulse(1);
		logchk(1);
		rd(`OFF_LOG_DATA);
		chk("log cmds", 32'(st[31:16]), 32'({`CMD_MONITOR, `CMD_MONITOR}));
		foreach (pwr[i])
		begin
			cmd(pwr[i]);
			chk("saves", 32'(saves), 32'(i + 1));
			chk("pm", 32'(st[9:8]), 32'(i + 1));
		end
		cmd(`CMD_STBY_A);
		chk("pm", 32'(st[9:8]), 32'h2);
		chk("saves", 32'(saves), 32'h3);
		cmd(`CMD_IDLE_B);
		chk("saves", 32'(saves), 32'h3);
		pulse(0);
		rd(`OFF_STATUS);
		chk("saves", 32'(saves), 32'h4);
		chk("pm", 32'(st[9:8]), 32'h2);
		pulse(1);
		logchk(1);
		do_reset();
		chk("enabled", 32'(st[4]), 32'h1);
		wr(`OFF_SUBCMD, 32'(`SUB_DISABLE));
		wr(`OFF_SIG_LO, 32'(`SIG_LOW_VAL));
		wr(`OFF_SIG_HI, 32'(`SIG_HIGH_VAL));
		wr(`OFF_DRVHEAD, 32'h10);
		wr(`OFF_COMMAND, 32'(`CMD_MONITOR));
		rd(`OFF_STATUS);
		chk("other drive", 32'(st[4:0]), 32'h10);
		wr(`OFF_DRVHEAD, 32'h0);
		cmd(`CMD_MONITOR);
		chk("disabled", 32'({st[4], st[3], stored, monitor_en}), 32'h0);
		cnt = int'(st[14:12]);
		pulse(1);
		logchk(1);
		rd(`OFF_LOG_DATA);
		chk("log hidden", st, 32'h0);
		run(`SUB_DISABLE, `SIG_LOW_VAL, 1'b1);
		pulse(2);
		cnt = 0;
		logchk(0);
		rd(`OFF_ERR_TOTAL);
		chk("error total", st, 32'h1);
		wr(`OFF_ERR_TOTAL, 32'h0);
		chk("write resp", 32'(br), 32'h0);
		rd(`OFF_ERR_TOTAL);
		chk("error total", st, 32'h0);
		rd(8'h30);
		chk("unmapped", 32'(rr), 32'h2);
		wr(8'h30, 32'h0);
		chk("unmapped write", 32'(br), 32'h2);
		report_and_stop();
	end

	initial
	begin
		#200000;
		mismatches++;
		report_and_stop();
	end
endmodule
